//--- bench/dut_model.sv
// Purpose: running user design beside the analyzer
// Assumes: monitored channels are a free counter
// Notes: a counter makes every trace sample predictable
module dut_model (
  // user clock and reset
  input  wire logic        user_clk_i,
  input  wire logic        rst_i,
  // stimulus from the core
  input  wire logic [31:0] stim_i,
  input  wire logic        stim_valid_i,
  // channel to the core, stimulus echo to the bench
  output logic      [31:0] monitor_o,
  output logic      [31:0] stim_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // never halted
  always_ff @(posedge user_clk_i or posedge rst_i) begin
    if (rst_i) monitor_o <= 32'h0;
    else monitor_o <= monitor_o + 32'h1;
  end
  always_ff @(posedge user_clk_i or posedge rst_i) begin
    if (rst_i) stim_seen_o <= 32'h0;
    else if (stim_valid_i) stim_seen_o <= stim_i;
  end
endmodule : dut_model

//--- bench/la_core_props.sv
// Purpose: port checks of the analyzer core
// Assumes: one bus master; rst_i resets both domains
// Notes: status flags lag, so they are left to the bench
module la_core_props #(
  parameter int MON_W  = 32,
  parameter int STIM_W = 32
) (
  // bus side
  input wire logic                      ref_clk_i,
  input wire logic                      rst_i,
  input wire la_pkg::avmm_req_t         bus_req_i,
  input wire logic [la_pkg::DATA_W-1:0] readdata_o,
  input wire logic                      waitrequest_o,
  // user side
  input wire logic                      user_clk_i,
  input wire logic [MON_W-1:0]          monitor_i,
  input wire logic [STIM_W-1:0]         stim_o,
  input wire logic                      stim_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import la_pkg::*;
  ////////////////////////////////////////////////////////////
  sequence s_req;
    (bus_req_i.read || bus_req_i.write) && waitrequest_o;
  endsequence
  sequence s_rd_ans;
    !waitrequest_o && bus_req_i.read;
  endsequence
  // trace reads cross domains, so the bound is generous
  a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i) s_req |-> ##[1:60] !waitrequest_o)
    else $error("bus answer late");
  a_answer_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i) !waitrequest_o |=> waitrequest_o)
    else $error("answer longer than one cycle");
  a_answer_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !waitrequest_o |-> bus_req_i.read || bus_req_i.write)
    else $error("answer without request");
  a_rdata_held: assert property (@(posedge ref_clk_i) disable iff (rst_i) !$stable(readdata_o) |-> s_rd_ans)
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_rd_ans and bus_req_i.address > OFF_RD_DATA |-> readdata_o == '0)
    else $error("unmapped read not zero");
  a_ctrl_reads_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_rd_ans and bus_req_i.address == OFF_CTRL |-> readdata_o == '0)
    else $error("control read not zero");
  a_stim_pulse: assert property (@(posedge user_clk_i) disable iff (rst_i) stim_valid_o |=> !stim_valid_o)
    else $error("stimulus strobe too long");
  a_stim_qualified: assert property (@(posedge user_clk_i) disable iff (rst_i) !$stable(stim_o) |-> stim_valid_o)
    else $error("stimulus moved without strobe");
endmodule : la_core_props

bind logic_analyzer_core la_core_props #(.MON_W(MON_W), .STIM_W(STIM_W)) u_la_core_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .user_clk_i(user_clk_i), .monitor_i(monitor_i), .stim_o(stim_o),
  .stim_valid_o(stim_valid_o));

//--- bench/logic_analyzer_core_tb.sv
// Purpose: random capture sessions of the analyzer core
// Assumes: user design modelled as a free counter
// Notes: DEPTH kept small for a short run
module logic_analyzer_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import la_pkg::*;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t %h %h", $time, g, e); end end
  localparam int DEPTH = 16;
  // startup capture waits for the free counter to reach this value
  localparam logic [31:0] BOOT_HIT = 32'h20;
  localparam logic [5:0] RA [7] = '{OFF_PRESTORE, OFF_MODE, OFF_PATTERN, OFF_DONT_CARE, OFF_STIM, OFF_CTRL, 6'h3C};
  localparam logic [31:0] RV [7] = '{32'h0, 32'h7, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0};
  logic ref_clk_i = 1'b0, user_clk_i = 1'b0, rst_i = 1'b1, waitrequest_o, stim_valid_o;
  logic [31:0] readdata_o, monitor, stim_o, seen, q, s, t, stim;
  avmm_req_t req = '0;
  int err_total = 0, n_tests = 0, pre;
  logic_analyzer_core #(.DEPTH(DEPTH), .STARTUP_EN(1'b1), .STARTUP_PATTERN(BOOT_HIT),
    .STARTUP_DONTCARE(32'h0), .STARTUP_PRESTORE(2'h1)) u_logic_analyzer_core (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus_req_i(req), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .user_clk_i(user_clk_i),
    .monitor_i(monitor), .stim_o(stim_o), .stim_valid_o(stim_valid_o));
  dut_model u_dut_model (.user_clk_i(user_clk_i), .rst_i(rst_i), .stim_i(stim_o),
    .stim_valid_i(stim_valid_o), .monitor_o(monitor), .stim_seen_o(seen));
  always #10 ref_clk_i = ~ref_clk_i;
  initial begin
    #7;
    forever #80 user_clk_i = ~user_clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 200);
    q = readdata_o;
    req <= '0;
    if (n >= 200) begin err_total++; print_verdict(); end
  endtask : bus
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, OFF_STATUS, 32'h0);
      k++;
    end while (q[b] !== v && k < 400);
    if (k >= 400) begin err_total++; print_verdict(); end
  endtask : poll
  // stage 1 ors two cared bits against zero, stage 2 ands them against ones
  function automatic logic [31:0] trig_of(input logic [31:0] x);
    logic [31:0] v;
    v = x + 32'h1;
    while (v[1:0] == 2'h3) v++;
    v++;
    while (v[1:0] != 2'h3) v++;
    return v;
  endfunction : trig_of
  task automatic session(input int p, input bit ab);
    pre = p * DEPTH / 4;
    stim = $urandom;
    s = ab ? monitor - 32'h5 : monitor + 32'h32;
    t = trig_of(s);
    bus(1'b1, OFF_PRESTORE, 32'(p));
    bus(1'b1, OFF_MODE, 32'h5);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFF_STAGE_SEL, 32'(i));
      bus(1'b1, OFF_PATTERN, i == 0 ? s : (i == 1 ? 32'h0 : 32'h3));
      bus(1'b1, OFF_DONT_CARE, i == 0 ? 32'h0 : 32'hFFFF_FFFC);
    end
    bus(1'b1, OFF_STIM, stim);
    bus(1'b1, OFF_CTRL, 32'h1);
    poll(STAT_BUSY_BIT, 1'b1);
    if (ab) bus(1'b1, OFF_CTRL, 32'h2);
    poll(STAT_BUSY_BIT, 1'b0);
    `CHK(q[STAT_DONE_BIT], !ab)
    `CHK(seen, stim)
    for (int j = 0; j < DEPTH && !ab; j++) begin
      bus(1'b1, OFF_RD_ADDR, 32'(j));
      bus(1'b0, OFF_RD_DATA, 32'h0);
      `CHK(q, t - 32'(pre) + 32'(j))
    end
  endtask : session
  initial begin
    void'($urandom(32'h42F8));
    repeat (6) @(posedge user_clk_i);
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, RA[i], 32'h0);
      `CHK(q, RV[i])
    end
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK(q[STAT_BOOT_AVAIL], 1'b1)
    poll(STAT_BOOT_HIT, 1'b1);
    for (int j = 0; j < DEPTH; j++) begin
      bus(1'b1, OFF_RD_ADDR, 32'(j));
      bus(1'b0, OFF_RD_DATA, 32'h0);
      `CHK(q, BOOT_HIT - 32'(DEPTH / 4) + 32'(j))
    end
    repeat (4) @(posedge user_clk_i);
    for (int r = 0; r < 4; r++) session(r == 0 ? 3 : (r == 1 ? 0 : int'($urandom % 4)), r == 2);
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK(q[STAT_BOOT_AVAIL], 1'b0)
    `CHK(q[STAT_BOOT_HIT], 1'b0)
    print_verdict();
  end
endmodule : logic_analyzer_core_tb

//--- logic/logic_analyzer_core.sv
// Purpose : on-chip logic analyzer with sequential triggers, trace buffer and stimulus
// Assumes : DEPTH is a power of two; MON_W and STIM_W are at most 32
// Notes   : registers on ref_clk_i, sampling and trace on user_clk_i
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
module logic_analyzer_core #(
  parameter int                   MON_W            = 32,
  parameter int                   DEPTH            = 1024,
  parameter int                   STAGES           = 3,
  parameter int                   STIM_W           = 32,
  parameter bit                   STARTUP_EN       = 1'b0,
  parameter logic [MON_W-1:0]     STARTUP_PATTERN  = '0,
  parameter logic [MON_W-1:0]     STARTUP_DONTCARE = '1,
  parameter bit                   STARTUP_AND      = 1'b1,
  parameter logic [1:0]           STARTUP_PRESTORE = 2'h0
) (
  // register bus clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  // avalon-mm slave
  input  wire la_pkg::avmm_req_t    bus_req_i,
  output logic [la_pkg::DATA_W-1:0] readdata_o,
  output logic                      waitrequest_o,
  // design under test
  input  wire logic                 user_clk_i,
  input  wire logic [MON_W-1:0]     monitor_i,
  output logic [STIM_W-1:0]         stim_o,
  output logic                      stim_valid_o
);
  import la_pkg::*;

  localparam int            AW      = $clog2(DEPTH);
  localparam int            SW      = (STAGES > 1) ? $clog2(STAGES) : 1;
  localparam logic [AW-1:0] ONE_A   = AW'(1);
  localparam logic [AW-1:0] LAST_A  = AW'(DEPTH - 1);
  localparam logic [SW-1:0] LAST_ST = SW'(STAGES - 1);
  localparam logic [SW-1:0] ONE_S   = SW'(1);

  function automatic logic [AW-1:0] pre_count(input logic [1:0] q);
    pre_count = AW'((DEPTH / 4) * int'(q));
  endfunction : pre_count

  //////////////////////////////////////////////////////////////////////////////
  // bus domain registers
  logic [PRESTORE_W-1:0] prestore_reg;
  logic [SW-1:0]         stage_sel_reg;
  logic [STAGES-1:0]     mode_reg;
  logic [MON_W-1:0]      pattern_reg   [STAGES];
  logic [MON_W-1:0]      dont_care_reg [STAGES];
  logic [STIM_W-1:0]     stim_reg;
  logic [AW-1:0]         rd_addr_reg;
  logic                  arm_tog_reg;
  logic                  abort_tog_reg;
  logic                  rd_req_tog_reg;
  logic                  rd_pending_reg;
  logic                  rd_ack_seen_reg;
  logic                  waitrequest_reg;
  logic [DATA_W-1:0]     readdata_reg;
  xfer_status_t          stat_meta_reg;
  xfer_status_t          stat_sync_reg;

  // user domain registers
  logic                  u_rst_meta_reg;
  logic                  u_rst_reg;
  logic [2:0]            cmd_meta_reg;
  logic [2:0]            cmd_sync_reg;
  logic [2:0]            cmd_seen_reg;
  cap_state_t            state_reg;
  logic [AW-1:0]         wp_reg;
  logic [AW-1:0]         cnt_reg;
  logic [AW-1:0]         pre_u_reg;
  logic [AW-1:0]         start_ptr_reg;
  logic [SW-1:0]         stage_reg;
  logic [SW-1:0]         last_stage_reg;
  logic [STAGES-1:0]     mode_u_reg;
  logic [MON_W-1:0]      pattern_u_reg [STAGES];
  logic [MON_W-1:0]      dc_u_reg      [STAGES];
  logic                  busy_u_reg;
  logic                  done_u_reg;
  logic                  boot_avail_reg;
  logic                  boot_used_reg;
  logic                  boot_hit_reg;
  logic                  boot_session_reg;
  logic                  rd_ack_tog_reg;
  logic [MON_W-1:0]      rd_data_u_reg;
  logic [STIM_W-1:0]     stim_reg_u;
  logic                  stim_valid_reg;
  logic [MON_W-1:0]      trace_mem [DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic req_live     = (bus_req_i.read | bus_req_i.write) & waitrequest_reg;
  wire logic sel_ctrl     = (bus_req_i.address == OFF_CTRL);
  wire logic sel_status   = (bus_req_i.address == OFF_STATUS);
  wire logic sel_prestore = (bus_req_i.address == OFF_PRESTORE);
  wire logic sel_stage    = (bus_req_i.address == OFF_STAGE_SEL);
  wire logic sel_mode     = (bus_req_i.address == OFF_MODE);
  wire logic sel_pattern  = (bus_req_i.address == OFF_PATTERN);
  wire logic sel_dc       = (bus_req_i.address == OFF_DONT_CARE);
  wire logic sel_stim     = (bus_req_i.address == OFF_STIM);
  wire logic sel_rd_addr  = (bus_req_i.address == OFF_RD_ADDR);
  wire logic sel_rd_data  = (bus_req_i.address == OFF_RD_DATA);
  wire logic stage_ok     = (int'(stage_sel_reg) < STAGES);
  wire logic rd_ack_edge  = stat_sync_reg.rd_ack ^ rd_ack_seen_reg;
  wire logic slow_read    = bus_req_i.read & sel_rd_data;
  // trace reads wait for the user clock side to fetch the word
  wire logic answer       = req_live & (~slow_read | (rd_pending_reg & rd_ack_edge));
  wire logic do_write     = answer & bus_req_i.write;
  // settings stay frozen while a session runs, the user side latches them at arm
  wire logic cfg_open     = ~stat_sync_reg.busy;
  wire logic cfg_write    = do_write & cfg_open;

  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] pattern_word;
  logic [DATA_W-1:0] dc_word;
  logic [DATA_W-1:0] rd_mux;

  assign status_word  = (DATA_W'(stat_sync_reg.busy)       << STAT_BUSY_BIT)
                      | (DATA_W'(stat_sync_reg.done)       << STAT_DONE_BIT)
                      | (DATA_W'(stat_sync_reg.boot_avail) << STAT_BOOT_AVAIL)
                      | (DATA_W'(stat_sync_reg.boot_hit)   << STAT_BOOT_HIT);
  assign pattern_word = stage_ok ? DATA_W'(pattern_reg[stage_sel_reg]) : UNMAPPED_RD;
  assign dc_word      = stage_ok ? DATA_W'(dont_care_reg[stage_sel_reg]) : UNMAPPED_RD;
  assign rd_mux       = sel_status   ? status_word
                      : sel_prestore ? DATA_W'(prestore_reg)
                      : sel_stage    ? DATA_W'(stage_sel_reg)
                      : sel_mode     ? DATA_W'(mode_reg)
                      : sel_pattern  ? pattern_word
                      : sel_dc       ? dc_word
                      : sel_stim     ? DATA_W'(stim_reg)
                      : sel_rd_addr  ? DATA_W'(rd_addr_reg)
                      : sel_rd_data  ? DATA_W'(rd_data_u_reg)
                      : UNMAPPED_RD;

  assign readdata_o    = readdata_reg;
  assign waitrequest_o = waitrequest_reg;

  //////////////////////////////////////////////////////////////////////////////
  // bus answer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_reg <= 1'b1;
      readdata_reg    <= UNMAPPED_RD;
    end else begin
      waitrequest_reg <= ~answer;
      if (answer & bus_req_i.read) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  // trace read handshake toward the user clock side
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_req_tog_reg  <= 1'b0;
      rd_pending_reg  <= 1'b0;
      rd_ack_seen_reg <= 1'b0;
    end else begin
      rd_ack_seen_reg <= stat_sync_reg.rd_ack;
      if (req_live & slow_read & ~rd_pending_reg) begin
        rd_req_tog_reg <= ~rd_req_tog_reg;
        rd_pending_reg <= 1'b1;
      end else if (answer & slow_read) begin
        rd_pending_reg <= 1'b0;
      end
    end
  end

  // status flags from the user clock side
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_meta_reg <= '0;
      stat_sync_reg <= '0;
    end else begin
      stat_meta_reg <= '{busy: busy_u_reg, done: done_u_reg, boot_avail: boot_avail_reg,
                         boot_hit: boot_hit_reg, rd_ack: rd_ack_tog_reg};
      stat_sync_reg <= stat_meta_reg;
    end
  end

  // control and settings
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arm_tog_reg   <= 1'b0;
      abort_tog_reg <= 1'b0;
      prestore_reg  <= PRESTORE_RST;
      stage_sel_reg <= '0;
      mode_reg      <= {STAGES{MODE_AND_RST}};
      stim_reg      <= STIM_W'(STIM_RST);
      rd_addr_reg   <= '0;
    end else begin
      if (do_write & sel_ctrl & bus_req_i.writedata[CTRL_ARM_BIT]) begin
        arm_tog_reg <= ~arm_tog_reg;
      end
      if (do_write & sel_ctrl & bus_req_i.writedata[CTRL_ABORT_BIT]) begin
        abort_tog_reg <= ~abort_tog_reg;
      end
      if (cfg_write & sel_prestore) begin
        prestore_reg <= bus_req_i.writedata[PRESTORE_W-1:0];
      end
      if (do_write & sel_stage) begin
        stage_sel_reg <= bus_req_i.writedata[SW-1:0];
      end
      if (cfg_write & sel_mode) begin
        mode_reg <= bus_req_i.writedata[STAGES-1:0];
      end
      if (cfg_write & sel_stim) begin
        stim_reg <= bus_req_i.writedata[STIM_W-1:0];
      end
      if (do_write & sel_rd_addr & ~rd_pending_reg) begin
        rd_addr_reg <= bus_req_i.writedata[AW-1:0];
      end
    end
  end

  // pattern and don't-care words of the selected stage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < STAGES; i++) begin
        pattern_reg[i]   <= MON_W'(PATTERN_RST);
        dont_care_reg[i] <= MON_W'(DONT_CARE_RST);
      end
    end else if (cfg_write & stage_ok) begin
      if (sel_pattern) begin
        pattern_reg[stage_sel_reg] <= bus_req_i.writedata[MON_W-1:0];
      end
      if (sel_dc) begin
        dont_care_reg[stage_sel_reg] <= bus_req_i.writedata[MON_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // user clock side: reset release and command crossing
  always_ff @(posedge user_clk_i or posedge rst_i) begin
    if (rst_i) begin
      u_rst_meta_reg <= 1'b1;
      u_rst_reg      <= 1'b1;
    end else begin
      u_rst_meta_reg <= 1'b0;
      u_rst_reg      <= u_rst_meta_reg;
    end
  end

  always_ff @(posedge user_clk_i or posedge u_rst_reg) begin
    if (u_rst_reg) begin
      cmd_meta_reg <= 3'h0;
      cmd_sync_reg <= 3'h0;
      cmd_seen_reg <= 3'h0;
    end else begin
      cmd_meta_reg <= {rd_req_tog_reg, abort_tog_reg, arm_tog_reg};
      cmd_sync_reg <= cmd_meta_reg;
      cmd_seen_reg <= cmd_sync_reg;
    end
  end

  wire logic arm_edge   = cmd_sync_reg[0] ^ cmd_seen_reg[0];
  wire logic abort_edge = cmd_sync_reg[1] ^ cmd_seen_reg[1];
  wire logic rd_edge    = cmd_sync_reg[2] ^ cmd_seen_reg[2];
  wire logic boot_start = (state_reg == CAP_IDLE) & boot_avail_reg & ~boot_used_reg & ~arm_edge;
  wire logic capturing  = (state_reg == CAP_PRE) | (state_reg == CAP_SEARCH) | (state_reg == CAP_POST);
  wire logic [AW-1:0] arm_pre  = pre_count(prestore_reg);
  wire logic [AW-1:0] boot_pre = pre_count(STARTUP_PRESTORE);
  wire logic [AW-1:0] post_cnt = LAST_A - pre_u_reg;

  //////////////////////////////////////////////////////////////////////////////
  // sequential trigger stages
  logic [STAGES-1:0] stage_hit;

  for (genvar g = 0; g < STAGES; g++) begin : g_stage
    trigger_stage_match #(
      .W (MON_W)
    ) u_match (
      .pattern_i   (pattern_u_reg[g]),
      .dont_care_i (dc_u_reg[g]),
      .and_mode_i  (mode_u_reg[g]),
      .sample_i    (monitor_i),
      .match_o     (stage_hit[g])
    );
  end

  wire logic cur_hit = stage_hit[stage_reg];
  wire logic trig_hit   = cur_hit & (stage_reg == last_stage_reg);
  // a zero post count ends the session on the trigger sample itself
  wire logic last_write = ((state_reg == CAP_POST) & (cnt_reg == ONE_A))
                        | ((state_reg == CAP_SEARCH) & trig_hit & (post_cnt == '0));

  // session settings latched at arm or at startup
  always_ff @(posedge user_clk_i or posedge u_rst_reg) begin
    if (u_rst_reg) begin
      mode_u_reg     <= {STAGES{MODE_AND_RST}};
      last_stage_reg <= '0;
      pre_u_reg      <= '0;
      for (int i = 0; i < STAGES; i++) begin
        pattern_u_reg[i] <= MON_W'(PATTERN_RST);
        dc_u_reg[i]      <= MON_W'(DONT_CARE_RST);
      end
    end else if (arm_edge) begin
      mode_u_reg     <= mode_reg;
      last_stage_reg <= LAST_ST;
      pre_u_reg      <= arm_pre;
      for (int i = 0; i < STAGES; i++) begin
        pattern_u_reg[i] <= pattern_reg[i];
        dc_u_reg[i]      <= dont_care_reg[i];
      end
    end else if (boot_start) begin
      mode_u_reg[0]    <= STARTUP_AND;
      last_stage_reg   <= '0;
      pre_u_reg        <= boot_pre;
      pattern_u_reg[0] <= STARTUP_PATTERN;
      dc_u_reg[0]      <= STARTUP_DONTCARE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // capture sequencer; the watched design is never stalled, only observed
  // free-running observation
  always_ff @(posedge user_clk_i or posedge u_rst_reg) begin
    if (u_rst_reg) begin
      state_reg     <= CAP_IDLE;
      wp_reg        <= '0;
      cnt_reg       <= '0;
      stage_reg     <= '0;
      start_ptr_reg <= '0;
    end else if (arm_edge) begin
      state_reg <= (arm_pre == '0) ? CAP_SEARCH : CAP_PRE;
      wp_reg    <= '0;
      cnt_reg   <= '0;
      stage_reg <= '0;
    end else if (abort_edge) begin
      state_reg <= CAP_IDLE;
    end else if (boot_start) begin
      state_reg <= (boot_pre == '0) ? CAP_SEARCH : CAP_PRE;
      wp_reg    <= '0;
      cnt_reg   <= '0;
      stage_reg <= '0;
    end else begin
      if (capturing) begin
        wp_reg <= wp_reg + ONE_A;
      end
      unique case (state_reg)
        CAP_IDLE, CAP_DONE: begin
        end
        CAP_PRE: begin
          cnt_reg <= cnt_reg + ONE_A;
          if (cnt_reg == pre_u_reg - ONE_A) begin
            state_reg <= CAP_SEARCH;
          end
        end
        CAP_SEARCH: begin
          if (trig_hit) begin
            start_ptr_reg <= wp_reg - pre_u_reg;
            cnt_reg       <= post_cnt;
            state_reg     <= (post_cnt == '0) ? CAP_DONE : CAP_POST;
          end else if (cur_hit) begin
            stage_reg <= stage_reg + ONE_S;
          end
        end
        CAP_POST: begin
          cnt_reg <= cnt_reg - ONE_A;
          if (cnt_reg == ONE_A) begin
            state_reg <= CAP_DONE;
          end
        end
      endcase
    end
  end

  // session flags
  always_ff @(posedge user_clk_i or posedge u_rst_reg) begin
    if (u_rst_reg) begin
      busy_u_reg       <= 1'b0;
      done_u_reg       <= 1'b0;
      boot_avail_reg   <= STARTUP_EN;
      boot_used_reg    <= 1'b0;
      boot_hit_reg     <= 1'b0;
      boot_session_reg <= 1'b0;
    end else if (arm_edge) begin
      busy_u_reg       <= 1'b1;
      done_u_reg       <= 1'b0;
      boot_avail_reg   <= 1'b0;
      boot_hit_reg     <= 1'b0;
      boot_session_reg <= 1'b0;
    end else if (abort_edge) begin
      busy_u_reg <= 1'b0;
    end else if (boot_start) begin
      busy_u_reg       <= 1'b1;
      boot_used_reg    <= 1'b1;
      boot_session_reg <= 1'b1;
    end else if (last_write) begin
      busy_u_reg   <= 1'b0;
      done_u_reg   <= 1'b1;
      boot_hit_reg <= boot_session_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trace memory; reads return samples in time order from the oldest one
  // sample on user clock
  always_ff @(posedge user_clk_i) begin
    if (capturing) begin
      trace_mem[wp_reg] <= monitor_i;
    end
    if (rd_edge) begin
      rd_data_u_reg <= trace_mem[start_ptr_reg + rd_addr_reg];
    end
  end

  always_ff @(posedge user_clk_i or posedge u_rst_reg) begin
    if (u_rst_reg) begin
      rd_ack_tog_reg <= 1'b0;
    end else if (rd_edge) begin
      rd_ack_tog_reg <= ~rd_ack_tog_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stimulus toward the design under test
  always_ff @(posedge user_clk_i or posedge u_rst_reg) begin
    if (u_rst_reg) begin
      stim_reg_u     <= STIM_W'(STIM_RST);
      stim_valid_reg <= 1'b0;
    end else begin
      stim_valid_reg <= arm_edge;
      if (arm_edge) begin
        stim_reg_u <= stim_reg;
      end
    end
  end

  assign stim_o       = stim_reg_u;
  assign stim_valid_o = stim_valid_reg;

endmodule : logic_analyzer_core

//--- logic/trigger_stage_match.sv
// Purpose : pattern compare of one sequential trigger stage
// Assumes : a set don't-care bit removes that channel from the compare
// Notes   : an all don't-care stage matches always in AND mode and never in OR mode
module trigger_stage_match #(
  parameter int W = 32
) (
  // stage setting
  input  wire logic [W-1:0] pattern_i,
  input  wire logic [W-1:0] dont_care_i,
  input  wire logic         and_mode_i,
  // sample
  input  wire logic [W-1:0] sample_i,
  // result
  output logic              match_o
);

  logic [W-1:0] care;
  logic [W-1:0] equal_bits;
  logic         all_hit;
  logic         any_hit;

  assign care       = ~dont_care_i;
  assign equal_bits = ~(sample_i ^ pattern_i) & care;
  assign all_hit    = (equal_bits == care);
  assign any_hit    = |equal_bits;
  assign match_o    = and_mode_i ? all_hit : any_hit;

endmodule : trigger_stage_match

//--- shared/la_pkg.sv
// Purpose : shared constants and types of the logic analyzer core
// Assumes : 32-bit word-aligned registers reached over Avalon-MM with waitrequest
// Notes   : the user design clock clocks the sampling side; the bus clock clocks the registers
package la_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESTORE  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_STAGE_SEL = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_MODE      = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_PATTERN   = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_DONT_CARE = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_STIM      = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_RD_ADDR   = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_RD_DATA   = 6'h24;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_ARM_BIT       = 0;
  localparam int CTRL_ABORT_BIT     = 1;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_DONE_BIT      = 1;
  localparam int STAT_BOOT_AVAIL    = 2;
  localparam int STAT_BOOT_HIT      = 3;
  localparam int PRESTORE_W         = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [PRESTORE_W-1:0] PRESTORE_RST  = 2'h0;
  localparam logic                  MODE_AND_RST  = 1'b1;
  localparam logic [DATA_W-1:0]     PATTERN_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0]     DONT_CARE_RST = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0]     STIM_RST      = 32'h0000_0000;
  localparam logic [DATA_W-1:0]     UNMAPPED_RD   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic boot_avail;
    logic boot_hit;
    logic rd_ack;
  } xfer_status_t;

  typedef enum logic [2:0] {
    CAP_IDLE,
    CAP_PRE,
    CAP_SEARCH,
    CAP_POST,
    CAP_DONE
  } cap_state_t;

endpackage : la_pkg
